/* File: rtl/uls_pkg.sv */
// Constants, register map and state type for the UART mode-control block.
// Assumes an 8-bit host register port and a UART core that sits outside.
package uls_pkg;

	// ----------------------------------------
	// Register offsets (4-bit register index)
	// ----------------------------------------
	localparam logic [3:0] OFS_THR      = 4'h0;
	localparam logic [3:0] OFS_IER      = 4'h1;
	localparam logic [3:0] OFS_LCR      = 4'h3;
	localparam logic [3:0] OFS_MCR      = 4'h4;
	localparam logic [3:0] OFS_EFR      = 4'h8;
	localparam logic [3:0] OFS_AFC1     = 4'h9;
	localparam logic [3:0] OFS_AFC2     = 4'hA;
	localparam logic [3:0] OFS_SECOND_XOFF_CHARACTER    = 4'hB;
	localparam logic [3:0] OFS_RXCTL    = 4'hC;
	localparam logic [3:0] OFS_STATUS   = 4'hD;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MCR_DTR        = 0;
	localparam int MCR_RTS        = 1;
	localparam int MCR_OP1        = 2;
	localparam int MCR_OP2        = 3;
	localparam int MCR_LOOP       = 4;
	localparam int IER_LSI        = 2;
	localparam int IER_SLEEP      = 4;
	localparam int EFR_ENH        = 4;
	localparam int EFR_SCD        = 5;
	localparam int AFC1_IDLE_IGN  = 4;
	localparam int AFC2_NINE_BIT  = 0;
	localparam int AFC2_AUTO_RTS  = 4;
	localparam int AFC2_RTS_INV   = 5;
	localparam int RXCTL_EN       = 0;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam logic       RX_EN_RESET = 1'b1;
	localparam int         IDLE_CHARS  = 4;

	typedef enum logic [1:0] {
		ST_AWAKE  = 2'b00,
		ST_ASLEEP = 2'b01,
		ST_LOW_POWER_INPUT = 2'b10
	} uls_state_t;

	function automatic logic uls_hit(input logic [3:0] addr, input logic [3:0] ofs, input logic strobe);
		uls_hit = strobe && (addr == ofs);
	endfunction

endpackage

/* File: rtl/uls_rx_if.sv */
// Received-character path between the mode controller and the multidrop filter.
// Both ends run on core_clk.
`timescale 1ns/1ps
interface uls_rx_if;
	logic       ch_valid;
	logic [7:0] ch_data;
	logic       ch_ninth;
	logic       ch_perr;
	logic       md_en;
	logic       scd_en;
	logic       lsi_en;
	logic [7:0] match_char;
	logic       host_en_wr;
	logic       host_en_val;
	logic       rx_enabled;
	logic       push_valid;
	logic [7:0] push_data;
	logic       push_perr;
	logic       lsi_event;

	modport filt (
		input  ch_valid, ch_data, ch_ninth, ch_perr, md_en, scd_en, lsi_en, match_char, host_en_wr, host_en_val,
		output rx_enabled, push_valid, push_data, push_perr, lsi_event
	);
	modport ctl (
		output ch_valid, ch_data, ch_ninth, ch_perr, md_en, scd_en, lsi_en, match_char, host_en_wr, host_en_val,
		input  rx_enabled, push_valid, push_data, push_perr, lsi_event
	);
endinterface

/* File: rtl/uls_multidrop.sv */
// Receiver enable and 9-bit multidrop address filter.
// Expects one ch_valid pulse per received character from the core.
`timescale 1ns/1ps
module uls_multidrop
	import uls_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset,
	uls_rx_if.filt    rx
);

	logic is_addr;
	logic is_match;
	logic auto_set;
	logic auto_clr;
	logic accept;
	logic rx_en;

	assign is_addr  = rx.ch_ninth;
	assign is_match = (rx.ch_data == rx.match_char);
	assign auto_set = rx.ch_valid && rx.md_en && rx.scd_en && is_addr && is_match;
	assign auto_clr = rx.ch_valid && rx.md_en && rx.scd_en && is_addr && !is_match;

	// ----------------------------------------
	// Acceptance per mode
	// ----------------------------------------
	always_comb begin
		if (!rx.md_en) begin
			accept = rx.ch_valid && rx_en;
		end else if (rx.scd_en) begin
			accept = rx.ch_valid && (is_addr ? is_match : rx_en);
		end else begin
			accept = rx.ch_valid && (is_addr || rx_en);
		end
	end

	// Hardware enable/disable beats a host write in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx_en <= RX_EN_RESET;
		end else if (auto_set) begin
			rx_en <= 1'b1;
		end else if (auto_clr) begin
			rx_en <= 1'b0;
		end else if (rx.host_en_wr) begin
			rx_en <= rx.host_en_val;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx.push_valid <= 1'b0;
			rx.push_data  <= 8'h00;
			rx.push_perr  <= 1'b0;
			rx.lsi_event  <= 1'b0;
		end else begin
			rx.push_valid <= accept;
			rx.push_data  <= rx.ch_data;
			// Address reports its ninth bit in the parity error slot
			rx.push_perr  <= rx.md_en ? is_addr : rx.ch_perr;
			rx.lsi_event  <= accept && rx.md_en && is_addr && rx.lsi_en;
		end
	end

	assign rx.rx_enabled = rx_en;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence md_char_s(logic addr);
		rx.ch_valid && rx.md_en && !rx.scd_en && (rx.ch_ninth == addr);
	endsequence

	md_data_drop_a: assert property (@(posedge core_clk) disable iff (reset)
		md_char_s(1'b0) ##0 !rx_en |=> !rx.push_valid)
		else $error("data kept while receiver disabled");
	md_addr_keep_a: assert property (@(posedge core_clk) disable iff (reset)
		md_char_s(1'b1) |=> rx.push_valid && rx.push_perr)
		else $error("address not stored with parity error");
	md_data_take_a: assert property (@(posedge core_clk) disable iff (reset)
		md_char_s(1'b0) ##0 rx_en |=> rx.push_valid && !rx.push_perr)
		else $error("enabled receiver dropped data");
	auto_match_en_a: assert property (@(posedge core_clk) disable iff (reset)
		auto_set |=> rx_en && rx.push_valid && rx.push_perr)
		else $error("matching address not taken");
	auto_miss_off_a: assert property (@(posedge core_clk) disable iff (reset)
		auto_clr |=> !rx_en && !rx.push_valid)
		else $error("non-matching address not dropped");

endmodule // uls_multidrop

/* File: rtl/uls_top.sv */
// Mode control around a UART core: loopback, sleep, low power, RS-485.
// Assumes the core, its FIFOs and baud generator sit outside on core_clk,
// and honour core_clk_en / baud_clk_en as clock gate enables.
`timescale 1ns/1ps
module uls_top
	import uls_pkg::*;
#(
	parameter int IDLE_CHARS_P = IDLE_CHARS
)(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [3:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	input  wire logic       low_power_input,
	output logic            tx_pin,
	input  wire logic       rx_pin,
	input  wire logic       cts_n_pin,
	input  wire logic       dsr_n_pin,
	input  wire logic       cd_n_pin,
	input  wire logic       ri_n_pin,
	output logic            rts_n_pin,
	output logic            dtr_n_pin,
	output logic            irq_pin_out,
	output logic            irq_pin_oe,
	input  wire logic       core_txd,
	output logic            core_rxd,
	output logic            core_cts,
	output logic            core_dsr,
	output logic            core_cd,
	output logic            core_ri,
	input  wire logic       core_irq,
	input  wire logic       core_int_pending,
	input  wire logic       core_tx_empty,
	input  wire logic       core_rx_empty,
	input  wire logic       core_char_tick,
	input  wire logic       core_hwfc_en,
	input  wire logic       core_hwfc_rts_n,
	output logic            thr_load,
	output logic      [7:0] thr_data,
	input  wire logic       core_rx_valid,
	input  wire logic [7:0] core_rx_data,
	input  wire logic       core_rx_ninth,
	input  wire logic       core_rx_perr,
	output logic            rx_push_valid,
	output logic      [7:0] rx_push_data,
	output logic            rx_push_perr,
	output logic            lsi_event,
	output logic            core_clk_en,
	output logic            baud_clk_en
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (IDLE_CHARS_P < 1 || IDLE_CHARS_P > 7) begin : g_chk
		$error("IDLE_CHARS_P must be 1 to 7");
	end

	localparam logic [2:0] IDLE_MAX = 3'(IDLE_CHARS_P);

	logic [7:0] interrupt_enable_register;
	logic [7:0] line_control_register;
	logic [7:0] modem_control_register;
	logic [7:0] enhanced_feature_register;
	logic [7:0] advanced_control_one;
	logic [7:0] advanced_control_two;
	logic [7:0] second_xoff_character;
	uls_state_t state;
	uls_state_t next_state;
	logic       bus_live;
	logic       thr_wr;
	logic       loop;
	logic       armed;
	logic       rx_eff;
	logic       rx_eff_q;
	logic [3:0] modem_eff;
	logic [3:0] modem_q;
	logic       modem_chg;
	logic [2:0] idle_cnt;
	logic       rx_idle;
	logic       enter_ok;
	logic       wake_ev;
	logic       tx_empty_q;
	logic       rts_pend;
	logic       auto_rts;
	logic       next_rts_n;
	logic [7:0] next_rdata;

	uls_rx_if rxi ();

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// Host pins are isolated in low power: writes and reads are ignored
	assign bus_live = (state != ST_LOW_POWER_INPUT) && !low_power_input;
	assign thr_wr   = bus_live && uls_hit(bus_addr, OFS_THR, bus_wr);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			interrupt_enable_register <= REG_RESET;
			line_control_register     <= REG_RESET;
			modem_control_register    <= REG_RESET;
			enhanced_feature_register <= REG_RESET;
			advanced_control_one      <= REG_RESET;
			advanced_control_two      <= REG_RESET;
			second_xoff_character     <= REG_RESET;
		end else if (bus_live) begin
			if (uls_hit(bus_addr, OFS_IER, bus_wr))   interrupt_enable_register <= bus_wdata;
			if (uls_hit(bus_addr, OFS_LCR, bus_wr))   line_control_register     <= bus_wdata;
			if (uls_hit(bus_addr, OFS_MCR, bus_wr))   modem_control_register    <= bus_wdata;
			if (uls_hit(bus_addr, OFS_EFR, bus_wr))   enhanced_feature_register <= bus_wdata;
			if (uls_hit(bus_addr, OFS_AFC1, bus_wr))  advanced_control_one      <= bus_wdata;
			if (uls_hit(bus_addr, OFS_AFC2, bus_wr))  advanced_control_two      <= bus_wdata;
			if (uls_hit(bus_addr, OFS_SECOND_XOFF_CHARACTER, bus_wr)) second_xoff_character     <= bus_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			thr_load <= 1'b0;
			thr_data <= 8'h00;
		end else begin
			thr_load <= thr_wr;
			if (thr_wr) thr_data <= bus_wdata;
		end
	end

	always_comb begin
		case (bus_addr)
			OFS_IER:    next_rdata = interrupt_enable_register;
			OFS_LCR:    next_rdata = line_control_register;
			OFS_MCR:    next_rdata = modem_control_register;
			OFS_EFR:    next_rdata = enhanced_feature_register;
			OFS_AFC1:   next_rdata = advanced_control_one;
			OFS_AFC2:   next_rdata = advanced_control_two;
			OFS_SECOND_XOFF_CHARACTER:  next_rdata = second_xoff_character;
			OFS_RXCTL:  next_rdata = {7'h00, rxi.rx_enabled};
			OFS_STATUS: next_rdata = {4'h0, rts_pend, rx_idle, state};
			default:    next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_rdata <= 8'h00;
		end else begin
			bus_rdata <= (bus_live && bus_rd) ? next_rdata : 8'h00;
		end
	end

	// ----------------------------------------
	// Loopback and pin muxing
	// ----------------------------------------
	assign loop      = modem_control_register[MCR_LOOP];
	assign rx_eff    = loop ? core_txd : rx_pin;
	assign modem_eff = loop ? {modem_control_register[MCR_RTS], modem_control_register[MCR_DTR],
	                           modem_control_register[MCR_OP2], modem_control_register[MCR_OP1]}
	                        : {~cts_n_pin, ~dsr_n_pin, ~cd_n_pin, ~ri_n_pin};

	// TX and DTR outputs idle high in loopback so the line sees marking; the interrupt pin output enable goes low
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tx_pin      <= 1'b1;
			core_rxd    <= 1'b1;
			dtr_n_pin   <= 1'b1;
			core_cts    <= 1'b0;
			core_dsr    <= 1'b0;
			core_cd     <= 1'b0;
			core_ri     <= 1'b0;
			irq_pin_out <= 1'b0;
			irq_pin_oe  <= 1'b0;
		end else begin
			tx_pin      <= loop ? 1'b1 : core_txd;
			core_rxd    <= rx_eff;
			dtr_n_pin   <= loop ? 1'b1 : ~modem_control_register[MCR_DTR];
			{core_cts, core_dsr, core_cd, core_ri} <= modem_eff;
			irq_pin_out <= core_irq;
			irq_pin_oe  <= !loop && bus_live;
		end
	end

	// ----------------------------------------
	// Sleep conditions
	// ----------------------------------------
	assign armed     = enhanced_feature_register[EFR_ENH] && interrupt_enable_register[IER_SLEEP];
	assign modem_chg = (modem_eff != modem_q);
	assign rx_idle   = (idle_cnt >= IDLE_MAX) || advanced_control_one[AFC1_IDLE_IGN];
	assign enter_ok  = armed && !modem_chg && rx_idle && core_tx_empty
	                   && !core_int_pending && core_rx_empty;
	assign wake_ev   = (rx_eff_q && !rx_eff) || thr_wr || modem_chg;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx_eff_q <= 1'b1;
			modem_q  <= 4'h0;
		end else begin
			rx_eff_q <= rx_eff;
			modem_q  <= modem_eff;
		end
	end

	// Counts core_char_tick character times while the receive line stays high, up to IDLE_MAX; a low clears it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			idle_cnt <= 3'h0;
		end else if (!rx_eff) begin
			idle_cnt <= 3'h0;
		end else if (core_char_tick && idle_cnt < IDLE_MAX) begin
			idle_cnt <= idle_cnt + 3'h1;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_AWAKE: begin
				if (low_power_input) next_state = ST_LOW_POWER_INPUT;
				else if (enter_ok && !wake_ev) next_state = ST_ASLEEP;
			end
			ST_ASLEEP: begin
				if (low_power_input) next_state = ST_LOW_POWER_INPUT;
				else if (wake_ev || !armed) next_state = ST_AWAKE;
			end
			ST_LOW_POWER_INPUT: begin
				if (!low_power_input) next_state = ST_AWAKE;
			end
			default: next_state = ST_AWAKE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) state <= ST_AWAKE;
		else state <= next_state;
	end

	assign core_clk_en = (state == ST_AWAKE);
	assign baud_clk_en = (state == ST_AWAKE);

	// ----------------------------------------
	// RTS control
	// ----------------------------------------
	assign auto_rts = advanced_control_two[AFC2_AUTO_RTS];

	// Pending from the transmit write until shifter drains; write wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rts_pend   <= 1'b0;
			tx_empty_q <= 1'b1;
		end else begin
			tx_empty_q <= core_tx_empty;
			if (thr_wr) rts_pend <= 1'b1;
			else if (core_tx_empty && !tx_empty_q) rts_pend <= 1'b0;
		end
	end

	always_comb begin
		if (auto_rts) begin
			next_rts_n = rts_pend ^ ~advanced_control_two[AFC2_RTS_INV];
		end else if (core_hwfc_en) begin
			next_rts_n = core_hwfc_rts_n;
		end else begin
			next_rts_n = ~modem_control_register[MCR_RTS];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) rts_n_pin <= 1'b1;
		else rts_n_pin <= loop ? 1'b1 : next_rts_n;
	end

	// ----------------------------------------
	// Multidrop filter
	// ----------------------------------------
	assign rxi.ch_valid    = core_rx_valid;
	assign rxi.ch_data     = core_rx_data;
	assign rxi.ch_ninth    = core_rx_ninth;
	assign rxi.ch_perr     = core_rx_perr;
	assign rxi.md_en       = advanced_control_two[AFC2_NINE_BIT];
	assign rxi.scd_en      = enhanced_feature_register[EFR_SCD];
	assign rxi.lsi_en      = interrupt_enable_register[IER_LSI];
	assign rxi.match_char  = second_xoff_character;
	assign rxi.host_en_wr  = bus_live && uls_hit(bus_addr, OFS_RXCTL, bus_wr);
	assign rxi.host_en_val = bus_wdata[RXCTL_EN];

	uls_multidrop u_md (
		.core_clk (core_clk),
		.reset    (reset),
		.rx       (rxi)
	);

	assign rx_push_valid = rxi.push_valid;
	assign rx_push_data  = rxi.push_data;
	assign rx_push_perr  = rxi.push_perr;
	assign lsi_event     = rxi.lsi_event;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence thr_load_s;
		thr_wr && auto_rts && !loop;
	endsequence

	loop_rx_path_a: assert property (@(posedge core_clk) disable iff (reset)
		loop |=> core_rxd == $past(core_txd) && tx_pin)
		else $error("loopback data path broken");
	loop_modem_a: assert property (@(posedge core_clk) disable iff (reset)
		loop |=> core_cd == $past(modem_control_register[MCR_OP2])
		         && core_ri == $past(modem_control_register[MCR_OP1]))
		else $error("loopback modem feed wrong");
	loop_irq_float_a: assert property (@(posedge core_clk) disable iff (reset)
		loop |=> !irq_pin_oe)
		else $error("interrupt driven in loopback");
	sleep_entry_a: assert property (@(posedge core_clk) disable iff (reset)
		state == ST_AWAKE ##1 state == ST_ASLEEP |-> $past(armed && core_tx_empty && core_rx_empty && !core_int_pending))
		else $error("sleep entered without conditions");
	sleep_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		state == ST_ASLEEP |-> !core_clk_en && !baud_clk_en)
		else $error("clocks running in sleep");
	sleep_wake_a: assert property (@(posedge core_clk) disable iff (reset)
		state == ST_ASLEEP && thr_wr && !low_power_input |=> state == ST_AWAKE)
		else $error("no wake on transmit load");
	low_power_a: assert property (@(posedge core_clk) disable iff (reset)
		low_power_input |=> state == ST_LOW_POWER_INPUT && !core_clk_en && !irq_pin_oe)
		else $error("low power not entered");
	auto_rts_a: assert property (@(posedge core_clk) disable iff (reset)
		thr_load_s ##1 (auto_rts && !loop) [*2] |-> rts_n_pin == advanced_control_two[AFC2_RTS_INV])
		else $error("auto RTS not asserted on write");
	hwfc_rts_a: assert property (@(posedge core_clk) disable iff (reset)
		!auto_rts && core_hwfc_en && !loop |=> rts_n_pin == $past(core_hwfc_rts_n))
		else $error("hardware flow RTS not followed");

endmodule // uls_top

/* File: testbench/uls_peer.sv */
// Partner model: stand-in for the core transmitter and the remote line side.
// Assumes thr_load pulses once per host write to the transmit holding slot.
`timescale 1ns/1ps
module uls_peer #(
	parameter int BIT_CYC = 4
)(
	input  wire logic       core_clk,
	input  wire logic       thr_load,
	input  wire logic [7:0] thr_data,
	input  wire logic [3:0] modem_n,
	input  wire logic       line_break,
	output logic            core_txd,
	output logic            core_tx_empty,
	output logic            rx_pin,
	output logic      [3:0] modem_pins
);
	// ----------------------------------------
	// Frame shifter: start, 8 data, stop
	// ----------------------------------------
	logic [9:0] sh   = 10'h3FF;
	int         cnt  = 0;
	int         bits = 0;

	assign core_txd      = sh[0];
	assign core_tx_empty = (bits == 0);
	// Line idles high; a held break is seen as a start bit
	assign rx_pin        = ~line_break;
	assign modem_pins    = modem_n;

	always @(posedge core_clk) begin
		if (thr_load) begin
			sh   <= {1'b1, thr_data, 1'b0};
			bits <= 10;
			cnt  <= 0;
		end else if (bits != 0) begin
			if (cnt == BIT_CYC - 1) begin
				cnt  <= 0;
				sh   <= {1'b1, sh[9:1]};
				bits <= bits - 1;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule // uls_peer

/* File: testbench/uls_top_tb.sv */
// Self-checking bench for uls_top with queue scoreboard.
// Assumes the package constants and a 25 MHz core_clk.
`timescale 1ns/1ps
module uls_top_tb
	import uls_pkg::*;
;
	logic        core_clk, reset, bus_wr, bus_rd, low_power_input, tx_pin, rx_pin, rts_n_pin, dtr_n_pin;
	logic        cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin, irq_pin_out, irq_pin_oe, core_txd, core_rxd;
	logic        core_cts, core_dsr, core_cd, core_ri, core_irq, core_int_pending, core_tx_empty;
	logic        core_rx_empty, core_char_tick, core_hwfc_en, core_hwfc_rts_n, thr_load, core_rx_valid;
	logic        core_rx_ninth, core_rx_perr, rx_push_valid, rx_push_perr, lsi_event, core_clk_en, baud_clk_en;
	logic        line_break, rd_d;
	logic [3:0]  bus_addr, modem_n, modem_pins;
	logic [7:0]  bus_wdata, bus_rdata, thr_data, core_rx_data, rx_push_data;
	logic [11:0] q[$];
	int          checks = 0;
	int          n_mismatch = 0;
	int          i, k, seed;

	assign {cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin} = modem_pins;
	uls_top #(.IDLE_CHARS_P(4)) dut_u (.*);
	uls_peer #(.BIT_CYC(4)) peer_u (.core_clk(core_clk), .thr_load(thr_load), .thr_data(thr_data),
		.modem_n(modem_n), .line_break(line_break), .core_txd(core_txd), .core_tx_empty(core_tx_empty),
		.rx_pin(rx_pin), .modem_pins(modem_pins));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// Compare, report and bus tasks
	// ----------------------------------------
	task summarize;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		cmp({11'h000, got}, {11'h000, exp});
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		if (a == OFS_THR && !low_power_input) q.push_back({4'h8, d});
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		q.push_back({4'h0, e});
		@(posedge core_clk);
		bus_rd <= 1'b0;
	endtask
	task ch(input logic [7:0] d, input logic n, input logic keep);
		@(posedge core_clk);
		core_rx_valid <= 1'b1;
		core_rx_data  <= d;
		core_rx_ninth <= n;
		if (keep) q.push_back({2'b01, n, n, d});
		@(posedge core_clk);
		core_rx_valid <= 1'b0;
	endtask
	task tick;
		@(posedge core_clk);
		core_char_tick <= 1'b1;
		@(posedge core_clk);
		core_char_tick <= 1'b0;
	endtask
	task wt(input logic v);
		for (i = 0; i < 120 && core_clk_en !== v; i++) @(negedge core_clk);
		cmp({10'h000, core_clk_en, baud_clk_en}, {10'h000, v, v});
	endtask
	task idle_tx;
		for (i = 0; i < 80 && core_tx_empty !== 1'b1; i++) @(negedge core_clk);
	endtask

	// Oldest note is matched against whichever result appears
	always @(posedge core_clk) begin
		rd_d <= bus_rd;
		if (rd_d) cmp({4'h0, bus_rdata}, q.size() ? q.pop_front() : 12'hFFF);
		if (rx_push_valid) cmp({2'b01, lsi_event, rx_push_perr, rx_push_data}, q.size() ? q.pop_front() : 12'hFFF);
		if (thr_load) cmp({4'h8, thr_data}, q.size() ? q.pop_front() : 12'hFFF);
	end

	initial begin
		repeat (50000) @(posedge core_clk);
		n_mismatch++;
		summarize();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h676D44A2;
		{reset, bus_wr, bus_rd, low_power_input, core_irq, core_int_pending, core_char_tick} = 7'h40;
		{core_hwfc_en, core_hwfc_rts_n, core_rx_valid, core_rx_ninth, core_rx_perr, line_break} = 6'h00;
		{core_rx_empty, bus_addr, modem_n, bus_wdata, core_rx_data} = {1'b1, 4'h0, 4'hF, 16'h0000};
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		rd(OFS_STATUS, 8'h00);
		wr(OFS_IER, 8'h14);
		rd(OFS_IER, 8'h14);
		rd(4'hF, 8'h00);
		wr(OFS_MCR, 8'h1F);
		line_break <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk1(core_rxd, 1'b1);
		cmp({8'h00, core_cts, core_dsr, core_cd, core_ri}, 12'h00F);
		chk1(irq_pin_oe, 1'b0);
		wr(OFS_THR, 8'($random(seed)));
		line_break <= 1'b0;
		for (i = 0; i < 60 && core_rxd !== 1'b0; i++) @(negedge core_clk);
		chk1(core_rxd, 1'b0);
		chk1(tx_pin, 1'b1);
		wr(OFS_MCR, 8'h14);
		repeat (3) @(negedge core_clk);
		cmp({8'h00, core_cts, core_dsr, core_cd, core_ri}, 12'h001);
		idle_tx();
		wr(OFS_MCR, 8'h02);
		repeat (3) @(negedge core_clk);
		chk1(irq_pin_oe, 1'b1);
		chk1(dtr_n_pin, 1'b1);
		chk1(rts_n_pin, 1'b0);
		@(posedge core_clk);
		{core_hwfc_en, core_hwfc_rts_n} <= 2'b11;
		repeat (3) @(negedge core_clk);
		chk1(rts_n_pin, 1'b1);
		@(posedge core_clk);
		core_hwfc_en <= 1'b0;
		for (k = 0; k < 2; k++) begin
			wr(OFS_AFC2, k ? 8'h30 : 8'h10);
			repeat (3) @(negedge core_clk);
			chk1(rts_n_pin, k == 0);
			wr(OFS_THR, 8'($random(seed)));
			repeat (2) @(negedge core_clk);
			chk1(rts_n_pin, k[0]);
			idle_tx();
			chk1(rts_n_pin, k[0]);
			repeat (2) @(negedge core_clk);
			chk1(rts_n_pin, k == 0);
		end
		wr(OFS_AFC2, 8'h00);
		wr(OFS_IER, 8'h10);
		repeat (4) tick();
		repeat (3) @(negedge core_clk);
		chk1(core_clk_en, 1'b1);
		// Hold an interrupt pending so arming alone cannot put the block to sleep
		@(posedge core_clk);
		core_int_pending <= 1'b1;
		wr(OFS_EFR, 8'h10);
		for (k = 0; k < 2; k++) begin
			@(posedge core_clk);
			{core_int_pending, core_rx_empty} <= k ? 2'b00 : 2'b11;
			repeat (5) @(negedge core_clk);
			chk1(core_clk_en, 1'b1);
		end
		@(posedge core_clk);
		{core_int_pending, core_rx_empty} <= 2'b01;
		wt(1'b0);
		@(posedge core_clk);
		line_break <= 1'b1;
		wt(1'b1);
		@(posedge core_clk);
		line_break <= 1'b0;
		repeat (3) tick();
		repeat (3) @(negedge core_clk);
		chk1(core_clk_en, 1'b1);
		tick();
		wt(1'b0);
		wr(OFS_THR, 8'($random(seed)));
		wt(1'b1);
		wt(1'b0);
		@(posedge core_clk);
		modem_n <= 4'hE;
		wt(1'b1);
		wt(1'b0);
		wr(OFS_IER, 8'h00);
		wt(1'b1);
		@(posedge core_clk);
		low_power_input <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk1(core_clk_en, 1'b0);
		chk1(irq_pin_oe, 1'b0);
		wr(OFS_IER, 8'h04);
		rd(OFS_EFR, 8'h00);
		@(posedge core_clk);
		low_power_input <= 1'b0;
		wt(1'b1);
		rd(OFS_IER, 8'h00);
		wr(OFS_IER, 8'h04);
		wr(OFS_LCR, 8'h38);
		wr(OFS_AFC2, 8'h01);
		wr(OFS_RXCTL, 8'h00);
		ch(8'($random(seed)), 1'b0, 1'b0);
		ch(8'h21, 1'b1, 1'b1);
		wr(OFS_RXCTL, 8'h01);
		ch(8'($random(seed)), 1'b0, 1'b1);
		ch(8'h22, 1'b1, 1'b1);
		wr(OFS_RXCTL, 8'h00);
		wr(OFS_EFR, 8'h20);
		wr(OFS_SECOND_XOFF_CHARACTER, 8'h5A);
		ch(8'($random(seed)), 1'b0, 1'b0);
		ch(8'h33, 1'b1, 1'b0);
		ch(8'h5A, 1'b1, 1'b1);
		ch(8'($random(seed)), 1'b0, 1'b1);
		ch(8'h33, 1'b1, 1'b0);
		ch(8'($random(seed)), 1'b0, 1'b0);
		repeat (5) @(negedge core_clk);
		cmp(12'(q.size()), 12'h000);
		summarize();
	end
endmodule // uls_top_tb
